// file: design/ioc_defs.svh
// constants of the internal oscillator control block: offsets, fields,
// reset values and counts; included by the design modules and the bench
`ifndef IOC_DEFS_SVH
`define IOC_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define IOC_ADDR_HF_CTRL 32'h0000_0000
`define IOC_ADDR_HF_CAL 32'h0000_0004
`define IOC_ADDR_LF_CTRL 32'h0000_0008
`define IOC_ADDR_IRQ_STAT 32'h0000_000C
`define IOC_ADDR_IRQ_EN 32'h0000_0010
`define IOC_ADDR_IRQ_CLR 32'h0000_0014
`define IOC_ADDR_T2_CAP 32'h0000_0018
`define IOC_ADDR_T3_CAP 32'h0000_001C
`define IOC_ADDR_CAP_MODE 32'h0000_0020

// ****************************************************************
// field positions
// ****************************************************************
`define IOC_HF_EN_BIT 7
`define IOC_HF_RDY_BIT 6
`define IOC_HF_SUSP_BIT 5
`define IOC_LF_EN_BIT 7
`define IOC_LF_RDY_BIT 6
`define IOC_LF_TRIM_MSB 5
`define IOC_LF_TRIM_LSB 2
`define IOC_DIV_MSB 1
`define IOC_IRQ_WAKE 0
`define IOC_IRQ_LFRDY 1
`define IOC_IRQ_CAP2 2
`define IOC_IRQ_CAP3 3
`define IOC_IRQ_W 4

// ****************************************************************
// reset values, codes and counts
// ****************************************************************
`define IOC_HF_CTRL_RST 8'hC0
`define IOC_HF_DIV_RST 2'h0
`define IOC_LF_DIV_RST 2'h0
`define IOC_HF_CAL_RST 8'h80
`define IOC_LF_TRIM_RST 4'h8
`define IOC_DIV8 2'h0
`define IOC_DIV4 2'h1
`define IOC_DIV2 2'h2
`define IOC_DIV1 2'h3
`define IOC_LF_SETTLE 8
`define IOC_RESP_OKAY 2'h0
`define IOC_RESP_SLVERR 2'h2

`endif

// file: design/ioc_div.sv
// oscillator post-divider: turns raw oscillator ticks into a divided
// tick pulse and a square-wave level; assumes ticks are clk-synchronous
`timescale 1ns/1ps
`include "ioc_defs.svh"
module ioc_div (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic tick,
	input wire logic run,
	input wire logic [1:0] sel,
	output logic pulse,
	output logic level
);
	import ioc_pkg::*;

	logic [2:0] cnt_r, cnt_nxt;
	logic pulse_r, pulse_nxt;
	logic level_r, level_nxt;

	function automatic logic [2:0] lim(input logic [1:0] s);
		case (s)
			`IOC_DIV8: lim = 3'h7;
			`IOC_DIV4: lim = 3'h3;
			`IOC_DIV2: lim = 3'h1;
			default: lim = 3'h0;
		endcase
	endfunction : lim

	always_comb begin
		cnt_nxt = cnt_r;
		pulse_nxt = 1'b0;
		level_nxt = level_r;
		if (!run) begin
			cnt_nxt = 3'h0;
		end else if (tick) begin
			// a count past a newly lowered limit restarts at the next tick
			if (cnt_r >= lim(sel)) begin
				cnt_nxt = 3'h0;
				pulse_nxt = 1'b1;
				level_nxt = ~level_r;
			end else begin
				cnt_nxt = cnt_r + 3'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 3'h0;
			pulse_r <= 1'b0;
			level_r <= 1'b0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
			pulse_r <= pulse_nxt;
			level_r <= level_nxt;
		end
	end

	assign pulse = pulse_r;
	assign level = level_r;

	// ****************************************************************
	// checks
	// ****************************************************************
	logic [3:0] tk_r;
	logic chg_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tk_r <= 4'h0;
			chg_r <= 1'b1;
		end else if (ce) begin
			tk_r <= pulse_nxt ? 4'h0 : (tick && run ? tk_r + 4'h1 : tk_r);
			chg_r <= pulse_nxt ? 1'b0 : (chg_r || sel != $past(sel) || !run);
		end
	end

	chk_div_ratio: assert property (@(posedge clk) disable iff (rst)
		(ce && pulse_nxt && !chg_r && sel == $past(sel) && run)
		|-> tk_r == {1'b0, lim(sel)})
		else $error("post-divider ratio wrong");
endmodule : ioc_div

// file: design/ioc_pkg.sv
// types of the internal oscillator control block
// assumes ioc_defs.svh is on the include path
package ioc_pkg;
	typedef enum logic [2:0] {
		IOC_ST_OFF = 3'b001,
		IOC_ST_RUN = 3'b010,
		IOC_ST_SUSP = 3'b100
	} ioc_hf_state_t;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} ioc_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ioc_axi_rsp_t;

	typedef struct packed {
		logic [2:0] port_match;
		logic [1:0] cmp_en;
		logic [1:0] cmp_out;
	} ioc_wake_t;
endpackage : ioc_pkg

// file: design/ioc_top.sv
// internal oscillator control: high- and low-frequency oscillator
// registers, suspend and wake, lf capture path, axi4-lite slave
// assumes all inputs synchronous to clk; oscillator ticks come from
// the analog cells as one-cycle pulses
//
// Overview of operation
// - after reset the system clock is flagged as sourced from the hf oscillator.
// - the hf output is divided by 8, 4, 2 or 1; code 00 is /8 at reset, 01 is /4.
// - writing one to suspend stops the hf oscillator and its derived clock; the lf path keeps running.
// - wake comes from a port 0/1/2 match or an enabled comparator reading low.
// - on wake the oscillator and derived clocks restart, interrupt or not.
// - a read-only ready flag shows one while the hf oscillator runs.
// - a calibration register sets the hf period, preloaded at reset.
// - the lf oscillator output goes through a 1/2/4/8 post-divider.
// - a four-bit lf trim in bits 5..2 runs from fastest 0000 to slowest 1111.
// - lf enable sits in bit 7 and a read-only lf ready in bit 6.
// - in capture mode timer 2 latches on lf fall and timer 3 on lf rise.
`timescale 1ns/1ps
`include "ioc_defs.svh"
module ioc_top #(
	parameter int LF_SETTLE_TICKS = `IOC_LF_SETTLE,
	// factory calibration preload; value is arbitrary here
	parameter logic [7:0] HF_CAL_RESET = `IOC_HF_CAL_RST,
	parameter logic [3:0] LF_TRIM_RESET = `IOC_LF_TRIM_RST
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input ioc_pkg::ioc_axi_req_t axi_req,
	output ioc_pkg::ioc_axi_rsp_t axi_rsp,
	input wire logic hf_osc_tick,
	input wire logic lf_osc_tick,
	input ioc_pkg::ioc_wake_t wake,
	input wire logic [15:0] timer2_count,
	input wire logic [15:0] timer3_count,
	output logic hf_osc_run,
	output logic [7:0] hf_osc_calibration,
	output logic lf_osc_run,
	output logic [3:0] lf_freq_trim,
	output logic hf_clk_en,
	output logic lf_clk_en,
	output logic lf_out,
	output logic system_clock_internal,
	output logic timer2_capture,
	output logic timer3_capture,
	output logic irq
);
	import ioc_pkg::*;

	localparam int SW = $clog2(LF_SETTLE_TICKS + 1);
	localparam logic [SW-1:0] SETTLE = SW'(LF_SETTLE_TICKS);

	// ****************************************************************
	// axi4-lite slave
	// ****************************************************************
	logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic [31:0] wa_r, wa_nxt, wd_r, wd_nxt;
	logic [3:0] ws_r, ws_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic awready, wready, arready, do_wr, wr_l0, wr_hit;
	logic hf_wr, cal_wr, lf_wr, en_wr, clr_wr, mode_wr;

	assign awready = !aw_have_r && !bvalid_r;
	assign wready = !w_have_r && !bvalid_r;
	assign arready = !rvalid_r;
	// write happens once both halves are held, in either order
	assign do_wr = aw_have_r && w_have_r;
	assign wr_l0 = do_wr && ws_r[0];
	assign hf_wr = wr_l0 && wa_r == `IOC_ADDR_HF_CTRL;
	assign cal_wr = wr_l0 && wa_r == `IOC_ADDR_HF_CAL;
	assign lf_wr = wr_l0 && wa_r == `IOC_ADDR_LF_CTRL;
	assign en_wr = wr_l0 && wa_r == `IOC_ADDR_IRQ_EN;
	assign clr_wr = wr_l0 && wa_r == `IOC_ADDR_IRQ_CLR;
	assign mode_wr = wr_l0 && wa_r == `IOC_ADDR_CAP_MODE;

	always_comb begin
		case (wa_r)
			`IOC_ADDR_HF_CTRL, `IOC_ADDR_HF_CAL, `IOC_ADDR_LF_CTRL,
			`IOC_ADDR_IRQ_EN, `IOC_ADDR_IRQ_CLR, `IOC_ADDR_CAP_MODE,
			`IOC_ADDR_IRQ_STAT, `IOC_ADDR_T2_CAP,
			`IOC_ADDR_T3_CAP: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// ****************************************************************
	// block state
	// ****************************************************************
	ioc_hf_state_t hf_state_r, hf_state_nxt;
	logic hf_en_r, hf_en_nxt, lf_en_r, lf_en_nxt;
	logic [1:0] hf_div_r, hf_div_nxt, lf_div_r, lf_div_nxt;
	logic [7:0] cal_r, cal_nxt;
	logic [3:0] trim_r, trim_nxt;
	logic [SW-1:0] settle_r, settle_nxt;
	logic [1:0] mode_r, mode_nxt;
	logic [15:0] t2_rl_r, t2_rl_nxt, t3_rl_r, t3_rl_nxt;
	logic cap2_r, cap2_nxt, cap3_r, cap3_nxt;
	logic lf_d_r;
	logic [`IOC_IRQ_W-1:0] stat_r, stat_nxt, ien_r, ien_nxt, ev;
	logic sysint_r;
	logic wake_evt, susp_req, hf_rdy, lf_rdy, lf_rise, lf_fall;
	logic hf_pulse, lf_pulse, lf_level;

	// any enabled source ends suspend, interrupt enabled or not
	assign wake_evt = |wake.port_match || |(wake.cmp_en & ~wake.cmp_out);
	assign susp_req = hf_wr && wd_r[`IOC_HF_SUSP_BIT];
	assign hf_rdy = hf_state_r == IOC_ST_RUN;
	assign lf_rdy = lf_en_r && settle_r == SETTLE;
	assign lf_rise = lf_level && !lf_d_r;
	assign lf_fall = !lf_level && lf_d_r;

	always_comb begin
		aw_have_nxt = aw_have_r;
		w_have_nxt = w_have_r;
		wa_nxt = wa_r;
		wd_nxt = wd_r;
		ws_nxt = ws_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (axi_req.awvalid && awready) begin
			aw_have_nxt = 1'b1;
			wa_nxt = axi_req.awaddr;
		end
		if (axi_req.wvalid && wready) begin
			w_have_nxt = 1'b1;
			wd_nxt = axi_req.wdata;
			ws_nxt = axi_req.wstrb;
		end
		if (do_wr) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_hit ? `IOC_RESP_OKAY : `IOC_RESP_SLVERR;
		end else if (bvalid_r && axi_req.bready) begin
			bvalid_nxt = 1'b0;
		end
		if (axi_req.arvalid && arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = `IOC_RESP_OKAY;
			case (axi_req.araddr)
				`IOC_ADDR_HF_CTRL: rdata_nxt = {24'h0, hf_en_r, hf_rdy,
					hf_state_r == IOC_ST_SUSP, 3'h0, hf_div_r};
				`IOC_ADDR_HF_CAL: rdata_nxt = {24'h0, cal_r};
				`IOC_ADDR_LF_CTRL: rdata_nxt = {24'h0, lf_en_r, lf_rdy,
					trim_r, lf_div_r};
				`IOC_ADDR_IRQ_STAT: rdata_nxt = {28'h0, stat_r};
				`IOC_ADDR_IRQ_EN: rdata_nxt = {28'h0, ien_r};
				`IOC_ADDR_IRQ_CLR: rdata_nxt = 32'h0;
				`IOC_ADDR_T2_CAP: rdata_nxt = {16'h0, t2_rl_r};
				`IOC_ADDR_T3_CAP: rdata_nxt = {16'h0, t3_rl_r};
				`IOC_ADDR_CAP_MODE: rdata_nxt = {30'h0, mode_r};
				default: begin
					rdata_nxt = 32'h0;
					rresp_nxt = `IOC_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && axi_req.rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	// ****************************************************************
	// oscillator control and capture
	// ****************************************************************
	always_comb begin
		hf_en_nxt = hf_wr ? wd_r[`IOC_HF_EN_BIT] : hf_en_r;
		hf_div_nxt = hf_wr ? wd_r[`IOC_DIV_MSB:0] : hf_div_r;
		cal_nxt = cal_wr ? wd_r[7:0] : cal_r;
		lf_en_nxt = lf_wr ? wd_r[`IOC_LF_EN_BIT] : lf_en_r;
		trim_nxt = lf_wr ? wd_r[`IOC_LF_TRIM_MSB:`IOC_LF_TRIM_LSB]
			: trim_r;
		lf_div_nxt = lf_wr ? wd_r[`IOC_DIV_MSB:0] : lf_div_r;
		mode_nxt = mode_wr ? wd_r[1:0] : mode_r;
		hf_state_nxt = hf_state_r;
		case (hf_state_r)
			IOC_ST_OFF: begin
				// an enable that carries suspend must not start the clock
				if (hf_en_nxt) begin
					hf_state_nxt = susp_req ? IOC_ST_SUSP : IOC_ST_RUN;
				end
			end
			IOC_ST_RUN: begin
				if (!hf_en_nxt) begin
					hf_state_nxt = IOC_ST_OFF;
				end else if (susp_req) begin
					hf_state_nxt = IOC_ST_SUSP;
				end
			end
			IOC_ST_SUSP: begin
				if (!hf_en_nxt) begin
					hf_state_nxt = IOC_ST_OFF;
				end else if (wake_evt) begin
					hf_state_nxt = IOC_ST_RUN;
				end
			end
			default: hf_state_nxt = IOC_ST_OFF;
		endcase
		// ready waits a fixed count of raw lf ticks after enable
		if (!lf_en_nxt) begin
			settle_nxt = '0;
		end else if (lf_osc_tick && settle_r != SETTLE) begin
			settle_nxt = settle_r + SW'(1);
		end else begin
			settle_nxt = settle_r;
		end
		cap2_nxt = mode_r[0] && lf_fall;
		cap3_nxt = mode_r[1] && lf_rise;
		t2_rl_nxt = cap2_nxt ? timer2_count : t2_rl_r;
		t3_rl_nxt = cap3_nxt ? timer3_count : t3_rl_r;
		ev = '0;
		ev[`IOC_IRQ_WAKE] = hf_state_r == IOC_ST_SUSP && wake_evt;
		ev[`IOC_IRQ_LFRDY] = lf_en_r && lf_osc_tick
			&& settle_r == SETTLE - SW'(1);
		ev[`IOC_IRQ_CAP2] = cap2_nxt;
		ev[`IOC_IRQ_CAP3] = cap3_nxt;
		ien_nxt = en_wr ? wd_r[`IOC_IRQ_W-1:0] : ien_r;
		// a new event wins over a clear in the same cycle
		stat_nxt = (stat_r & ~(clr_wr ? wd_r[`IOC_IRQ_W-1:0] : '0)) | ev;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			wa_r <= 32'h0;
			wd_r <= 32'h0;
			ws_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `IOC_RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= `IOC_RESP_OKAY;
			rdata_r <= 32'h0;
			hf_state_r <= IOC_ST_RUN;
			hf_en_r <= 1'(`IOC_HF_CTRL_RST >> `IOC_HF_EN_BIT);
			hf_div_r <= `IOC_HF_DIV_RST;
			cal_r <= HF_CAL_RESET;
			lf_en_r <= 1'b0;
			trim_r <= LF_TRIM_RESET;
			lf_div_r <= `IOC_LF_DIV_RST;
			settle_r <= '0;
			mode_r <= 2'h0;
			t2_rl_r <= 16'h0;
			t3_rl_r <= 16'h0;
			cap2_r <= 1'b0;
			cap3_r <= 1'b0;
			lf_d_r <= 1'b0;
			stat_r <= '0;
			ien_r <= '0;
			sysint_r <= 1'b1;
		end else if (ce) begin
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			wa_r <= wa_nxt;
			wd_r <= wd_nxt;
			ws_r <= ws_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			hf_state_r <= hf_state_nxt;
			hf_en_r <= hf_en_nxt;
			hf_div_r <= hf_div_nxt;
			cal_r <= cal_nxt;
			lf_en_r <= lf_en_nxt;
			trim_r <= trim_nxt;
			lf_div_r <= lf_div_nxt;
			settle_r <= settle_nxt;
			mode_r <= mode_nxt;
			t2_rl_r <= t2_rl_nxt;
			t3_rl_r <= t3_rl_nxt;
			cap2_r <= cap2_nxt;
			cap3_r <= cap3_nxt;
			lf_d_r <= lf_level;
			stat_r <= stat_nxt;
			ien_r <= ien_nxt;
			sysint_r <= sysint_r;
		end
	end

	ioc_div u_hf_div (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.tick(hf_osc_tick),
		.run(hf_rdy),
		.sel(hf_div_r),
		.pulse(hf_pulse),
		.level()
	);

	ioc_div u_lf_div (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.tick(lf_osc_tick),
		.run(lf_en_r),
		.sel(lf_div_r),
		.pulse(lf_pulse),
		.level(lf_level)
	);

	assign axi_rsp.awready = awready;
	assign axi_rsp.wready = wready;
	assign axi_rsp.bvalid = bvalid_r;
	assign axi_rsp.bresp = bresp_r;
	assign axi_rsp.arready = arready;
	assign axi_rsp.rvalid = rvalid_r;
	assign axi_rsp.rdata = rdata_r;
	assign axi_rsp.rresp = rresp_r;
	assign hf_osc_run = hf_rdy;
	assign hf_osc_calibration = cal_r;
	assign lf_osc_run = lf_en_r;
	assign lf_freq_trim = trim_r;
	// gate with the state so no pulse escapes on the suspend edge
	assign hf_clk_en = hf_pulse && hf_rdy;
	assign lf_clk_en = lf_pulse;
	assign lf_out = lf_level;
	assign system_clock_internal = sysint_r;
	assign timer2_capture = cap2_r;
	assign timer3_capture = cap3_r;
	assign irq = |(stat_r & ien_r);

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_enter_susp;
		ce && hf_state_r == IOC_ST_RUN && susp_req && hf_en_nxt;
	endsequence
	sequence s_wake_up;
		ce && hf_state_r == IOC_ST_SUSP && wake_evt && hf_en_nxt;
	endsequence

	chk_susp_entry: assert property (s_enter_susp |=>
		hf_state_r == IOC_ST_SUSP && !hf_clk_en && !hf_osc_run)
		else $error("suspend write did not stop the oscillator");
	chk_susp_gate: assert property (hf_state_r == IOC_ST_SUSP
		|-> !hf_clk_en)
		else $error("derived clock ran during suspend");
	chk_wake_resume: assert property (s_wake_up |=>
		hf_rdy && stat_r[`IOC_IRQ_WAKE])
		else $error("wake did not restart the oscillator");
	chk_wake_source: assert property ((ce && hf_state_r == IOC_ST_SUSP
		&& !wake_evt && hf_en_nxt) |=> hf_state_r == IOC_ST_SUSP)
		else $error("suspend left without a wake event");
	chk_sys_source: assert property (system_clock_internal)
		else $error("system clock not flagged internal");
	chk_cal_write: assert property (ce && cal_wr |=>
		hf_osc_calibration == $past(wd_r[7:0]))
		else $error("calibration write lost");
	chk_lf_settle: assert property ((ce && lf_wr && !lf_en_r
		&& wd_r[`IOC_LF_EN_BIT]) |=> !lf_rdy)
		else $error("lf ready before settling");
	chk_t2_capture: assert property ((ce && mode_r[0] && lf_fall)
		|=> t2_rl_r == $past(timer2_count) && timer2_capture)
		else $error("timer 2 capture missed");
	chk_t3_capture: assert property ((ce && mode_r[1] && lf_rise)
		|=> t3_rl_r == $past(timer3_count) && timer3_capture)
		else $error("timer 3 capture missed");
	chk_hf_ready: assert property ((ce && hf_wr
		&& !wd_r[`IOC_HF_EN_BIT]) |=> !hf_rdy && !hf_osc_run)
		else $error("ready stayed high with oscillator off");
endmodule : ioc_top

// file: tb/tb_top.sv
// self-checking bench for the internal oscillator control block
// assumes ioc_pkg is compiled first and ioc_defs.svh is on the include path
`timescale 1ns/1ps
`include "ioc_defs.svh"
module tb_top;
	import ioc_pkg::*;
	// calibration preload given to the design; value is arbitrary
	localparam logic [7:0] CAL_RST = 8'h3C;
	logic clk, rst, ce, hf_osc_tick, lf_osc_tick, hf_tick_en, lf_tick_en;
	ioc_axi_req_t req;
	ioc_axi_rsp_t rsp;
	ioc_wake_t wk;
	logic [15:0] t2c, t3c;
	logic hf_osc_run, lf_osc_run, hf_clk_en, lf_clk_en, lf_out, sys_int;
	logic timer2_capture, timer3_capture, irq;
	logic [7:0] hf_cal;
	logic [3:0] lf_trim;
	int fails = 0;
	int cmp_count = 0;
	int seed = 21353;
	logic [33:0] exp_rd[$];
	logic [1:0] exp_b[$];
	// wake sources: three port matches, then each comparator reading low
	logic [6:0] pats[5] = '{7'h1F, 7'h2F, 7'h4F, 7'h0E, 7'h0D};

	ioc_top #(.LF_SETTLE_TICKS(2), .HF_CAL_RESET(CAL_RST)) ioc_top_i (
		.clk(clk), .rst(rst), .ce(ce), .axi_req(req), .axi_rsp(rsp),
		.hf_osc_tick(hf_osc_tick), .lf_osc_tick(lf_osc_tick), .wake(wk),
		.timer2_count(t2c), .timer3_count(t3c), .hf_osc_run(hf_osc_run),
		.hf_osc_calibration(hf_cal), .lf_osc_run(lf_osc_run),
		.lf_freq_trim(lf_trim), .hf_clk_en(hf_clk_en), .lf_clk_en(lf_clk_en),
		.lf_out(lf_out), .system_clock_internal(sys_int),
		.timer2_capture(timer2_capture), .timer3_capture(timer3_capture),
		.irq(irq));

	always #2.5 clk = ~clk;

	// ****************************************************************
	// oscillator ticks: every other cycle, so a divided period is 2*div
	// ****************************************************************
	always @(posedge clk) begin
		hf_osc_tick <= hf_tick_en & ~hf_osc_tick;
		lf_osc_tick <= lf_tick_en & ~lf_osc_tick;
	end

	// ****************************************************************
	// compare and bus tasks
	// ****************************************************************
	task automatic check(input logic [33:0] e, input logic [33:0] g,
			input string what);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t %s: expected %h got %h", $time, what, e, g);
		end
	endtask : check

	task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
		check(e, g, "read data");
	endtask : cmp_rd

	task automatic cmp_b(input logic [1:0] e, input logic [1:0] g);
		check(34'(e), 34'(g), "write response");
	endtask : cmp_b

	task automatic cmp_pin(input logic [33:0] e, input logic [33:0] g);
		check(e, g, "pin value");
	endtask : cmp_pin

	// the leading edge keeps a release and the next raise apart
	task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
			input logic [3:0] s = 4'hF, input logic [1:0] er = `IOC_RESP_OKAY);
		@(posedge clk);
		exp_b.push_back(er);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= s;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge clk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
		end while (!(rsp.bvalid === 1'b1));
		req.bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [31:0] a, input logic [31:0] ed,
			input logic [1:0] er = `IOC_RESP_OKAY);
		@(posedge clk);
		exp_rd.push_back({er, ed});
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge clk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
		end while (!(rsp.rvalid === 1'b1));
		req.rready <= 1'b0;
	endtask : axi_read

	// first two gaps are discarded: a select change lands at the next tick
	task automatic pulse_gap(input bit lf, output int gap);
		for (int k = 0; k < 3; k++) begin
			gap = 0;
			do begin
				@(posedge clk);
				gap++;
			end while ((lf ? lf_clk_en : hf_clk_en) !== 1'b1 && gap < 100);
		end
	endtask : pulse_gap

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	// ****************************************************************
	// response monitor: oldest note against each answer
	// ****************************************************************
	always @(posedge clk) begin
		if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
			if (exp_rd.size() == 0) check(0, 1, "unexpected read");
			else cmp_rd(exp_rd.pop_front(), {rsp.rresp, rsp.rdata});
		end
		if (rsp.bvalid === 1'b1 && req.bready === 1'b1) begin
			if (exp_b.size() == 0) check(0, 1, "unexpected write");
			else cmp_b(exp_b.pop_front(), rsp.bresp);
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		report_and_stop();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		int gap;
		int n0;
		logic [31:0] r;
		clk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		req = '0;
		wk = 7'h0F;
		hf_osc_tick = 1'b0;
		lf_osc_tick = 1'b0;
		hf_tick_en = 1'b1;
		lf_tick_en = 1'b0;
		t2c = 16'h0000;
		t3c = 16'h0000;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		cmp_pin(1, sys_int);
		cmp_pin({1'b1, 1'b0, 4'h8, CAL_RST},
			{hf_osc_run, lf_osc_run, lf_trim, hf_cal});
		axi_read(`IOC_ADDR_HF_CTRL, 32'hC0);
		axi_read(`IOC_ADDR_HF_CAL, {24'h0, CAL_RST});
		axi_read(`IOC_ADDR_LF_CTRL, 32'h20);
		axi_read(32'h40, 0, `IOC_RESP_SLVERR);
		r = $random(seed);
		axi_write(32'h44, r, 4'hF, `IOC_RESP_SLVERR);
		axi_write(`IOC_ADDR_HF_CAL, r);
		axi_write(`IOC_ADDR_HF_CAL, ~r, 4'hE);
		axi_read(`IOC_ADDR_HF_CAL, {24'h0, r[7:0]});
		cmp_pin(r[7:0], hf_cal);
		for (int s = 0; s < 4; s++) begin
			axi_write(`IOC_ADDR_HF_CTRL, 32'hFFFF_FF9C | s);
			axi_read(`IOC_ADDR_HF_CTRL, 32'hC0 | s);
			pulse_gap(1'b0, gap);
			cmp_pin(2 * (8 >> s), gap);
		end
		axi_write(`IOC_ADDR_HF_CTRL, 32'h03);
		cmp_pin(0, hf_osc_run);
		axi_read(`IOC_ADDR_HF_CTRL, 32'h03);
		axi_write(`IOC_ADDR_IRQ_EN, 32'h1);
		// the system clock stays on the internal source with the hf oscillator off
		cmp_pin(1, sys_int);
		axi_write(`IOC_ADDR_HF_CTRL, 32'hA3);
		wk <= 7'h00;
		n0 = 0;
		for (int k = 0; k < 40; k++) begin
			@(posedge clk);
			n0 += hf_clk_en;
		end
		cmp_pin({3'b0, 16'd0}, {hf_osc_run, irq, lf_out, n0[15:0]});
		axi_read(`IOC_ADDR_HF_CTRL, 32'hA3);
		for (int i = 0; i < 5; i++) begin
			axi_write(`IOC_ADDR_HF_CTRL, 32'hA3);
			wk <= pats[i];
			repeat (3) @(posedge clk);
			wk <= 7'h0F;
			cmp_pin(2'b11, {hf_osc_run, irq});
			axi_read(`IOC_ADDR_HF_CTRL, 32'hC3);
			axi_read(`IOC_ADDR_IRQ_STAT, 32'h1);
			axi_write(`IOC_ADDR_IRQ_CLR, 32'h1);
			cmp_pin(0, irq);
		end
		pulse_gap(1'b0, gap);
		cmp_pin(2, gap);
		axi_write(`IOC_ADDR_IRQ_EN, 32'h0);
		axi_write(`IOC_ADDR_HF_CTRL, 32'hA3);
		wk <= 7'h2F;
		repeat (3) @(posedge clk);
		wk <= 7'h0F;
		cmp_pin(2'b10, {hf_osc_run, irq});
		axi_read(`IOC_ADDR_IRQ_STAT, 32'h1);
		axi_write(`IOC_ADDR_IRQ_CLR, 32'h1);
		axi_write(`IOC_ADDR_IRQ_EN, 32'hE);
		axi_write(`IOC_ADDR_LF_CTRL, 32'hBF);
		cmp_pin({2'b11, 4'hF}, {lf_osc_run, irq === 1'b0, lf_trim});
		axi_read(`IOC_ADDR_LF_CTRL, 32'hBF);
		lf_tick_en <= 1'b1;
		repeat (10) @(posedge clk);
		axi_read(`IOC_ADDR_LF_CTRL, 32'hFF);
		cmp_pin(1, irq);
		for (int s = 0; s < 4; s++) begin
			axi_write(`IOC_ADDR_LF_CTRL, 32'h80 | (s[0] ? 32'h3C : 32'h0) | s);
			axi_read(`IOC_ADDR_LF_CTRL, 32'hC0 | (s[0] ? 32'h3C : 32'h0) | s);
			pulse_gap(1'b1, gap);
			cmp_pin(2 * (8 >> s), gap);
		end
		r = $random(seed);
		t2c <= r[15:0];
		t3c <= r[31:16];
		axi_write(`IOC_ADDR_CAP_MODE, 32'h3);
		for (int k = 0; k < 200 && timer2_capture !== 1'b1; k++) @(posedge clk);
		cmp_pin(2'b10, {timer2_capture, lf_out});
		for (int k = 0; k < 200 && timer3_capture !== 1'b1; k++) @(posedge clk);
		cmp_pin(2'b11, {timer3_capture, lf_out});
		// clock enable low: the lf square wave must hold its level
		ce <= 1'b0;
		@(posedge clk);
		n0 = lf_out;
		repeat (6) @(posedge clk);
		cmp_pin(n0, lf_out);
		ce <= 1'b1;
		axi_write(`IOC_ADDR_CAP_MODE, 32'h0);
		axi_read(`IOC_ADDR_T2_CAP, {16'h0, r[15:0]});
		axi_read(`IOC_ADDR_T3_CAP, {16'h0, r[31:16]});
		axi_read(`IOC_ADDR_IRQ_STAT, 32'hE);
		axi_write(`IOC_ADDR_IRQ_CLR, 32'hF);
		axi_read(`IOC_ADDR_IRQ_STAT, 32'h0);
		cmp_pin(0, irq);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		axi_read(`IOC_ADDR_HF_CTRL, 32'hC0);
		axi_read(`IOC_ADDR_LF_CTRL, 32'h20);
		cmp_pin(3'b100, {sys_int, irq, lf_osc_run});
		repeat (4) @(posedge clk);
		report_and_stop();
	end
endmodule : tb_top
